// File: test/sadc_ana_model.sv
// Behavioural analog cell facing the converter control
`timescale 1ns/1ps
module sadc_ana_model
(
    input  wire logic            pclk,
    input  wire logic            ana_power_on,
    input  wire logic            ana_convert,
    input  wire logic [2:0]      ana_channel,
    output sadc_pkg::sadc_data_t ana_result
);
    import sadc_pkg::*;
    logic tgl_r = 1'b0;
    always @(posedge pclk)
        tgl_r <= ~tgl_r;
    // Valid code only while powered and converting, else a moving pattern
    assign ana_result = (ana_power_on && ana_convert) ?
                        {ana_channel, 7'h2B} : {5{tgl_r, ~tgl_r}};
endmodule // sadc_ana_model

// File: test/sadc_top_tb.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`include "sadc_consts.svh"
module sadc_top_tb;
    import sadc_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic        pclk = 0, presetn, psel, penable, pwrite, ext_trig, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, v;
    logic        pready, pslverr, ana_power_on, ana_sample, ana_convert;
    logic        adc_clk, dma_req, dma_size_16, irq;
    logic [5:0]  int_trig;
    logic [2:0]  ana_channel;
    sadc_data_t  ana_result;
    logic [63:0] exp_q[$];
    int          mismatches, comparisons, cyc, dmas, rises, n, r, convs, cv;
    int          clen, slen, cexp, sexp, seed;

    sadc_top u_sadc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .int_trig(int_trig), .ext_trig(ext_trig), .ana_result(ana_result),
        .ana_power_on(ana_power_on), .ana_sample(ana_sample),
        .ana_convert(ana_convert), .ana_channel(ana_channel),
        .adc_clk(adc_clk), .dma_req(dma_req), .dma_size_16(dma_size_16),
        .irq(irq));
    sadc_ana_model u_sadc_ana_model (.pclk(pclk),
        .ana_power_on(ana_power_on), .ana_convert(ana_convert),
        .ana_channel(ana_channel), .ana_result(ana_result));

    always #25 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string s, input logic [31:0] seen, e);
        comparisons++;
        if (seen !== e)
        begin
            mismatches++;
            $display("ERROR %s exp %h seen %h", s, e, seen);
        end
    endtask

    task automatic end_of_test;
        if (mismatches == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic logic [31:0] res(input logic [2:0] c);
        return {22'h0, c, 7'h2B};
    endfunction

    // APB transfer; reads note the expected word and mask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, m);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w)
            exp_q.push_back({m, d});
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Configure, start by mode t, wait for both results
    task automatic run(input logic [31:0] cfg, input int d, sh, t);
        cexp = 20 * (d + 1);
        sexp = 2 * (sh + 1) * (d + 1);
        n = convs + 2;
        apb(1, `SADC_A_CFG, cfg, 0);
        if (t == 0 || t == 8)
            apb(1, `SADC_A_CMD, 32'h2, 0);
        else
        begin
            if (t == 7)
                ext_trig <= 1'b1;
            else
                int_trig <= 6'h1 << (t - 1);
            repeat (6) @(posedge pclk);
            ext_trig <= 1'b0;
            int_trig <= 6'h0;
        end
        if (t == 8)
            apb(1, `SADC_A_CMD, 32'h2, 0);
        while (convs < n)
            @(posedge pclk);
        repeat (3) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk)
    begin
        logic [63:0] q;
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
        begin
            q = exp_q.pop_front();
            if (q[63:32] != 0)
                chk("prdata", prdata & q[63:32], q[31:0] & q[63:32]);
        end
    end

    always @(posedge pclk)
    begin
        cyc++;
        dmas += (dma_req === 1'b1);
        if (ana_convert === 1'b1)
            clen++;
        else if (clen > 0)
        begin
            chk("conv", clen, cexp);
            clen = 0;
            convs++;
        end
        if (ana_sample === 1'b1)
            slen++;
        else if (slen > 0)
        begin
            chk("sample", slen, sexp);
            slen = 0;
        end
        if (cyc == 30000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    always @(posedge adc_clk)
        rises++;
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'h2D2B;
        {presetn, psel, penable, pwrite, ext_trig} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        int_trig = 6'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("dma_size_16", dma_size_16, 1);
        apb(0, `SADC_A_CFG, 0, ALL);
        apb(0, `SADC_A_FLAGS, 0, ALL);
        v = $random(seed);
        apb(1, `SADC_A_CFG, v, 0);
        apb(0, `SADC_A_CFG, v & `SADC_CFG_MASK, ALL);
        apb(1, `SADC_A_CMD, 32'h1, 0);
        apb(0, `SADC_A_CFG, 0, ALL);
        apb(0, 8'h08, 0, ALL);
        chk("pslverr", err, 1);
        apb(1, `SADC_A_CHEN, 32'hA, 0);
        apb(0, `SADC_A_CHST, 32'hA, ALL);
        apb(1, `SADC_A_IEN, 32'h10000, 0);
        run(32'h02000100, 1, 2, 0);
        chk("irq", irq, 1);
        apb(0, `SADC_A_FLAGS, 32'h3000A, ALL);
        run(32'h02000100, 1, 2, 0);
        apb(0, `SADC_A_FLAGS, 32'h30A0A, ALL);
        apb(0, `SADC_A_FLAGS, 32'h1000A, ALL);
        apb(0, `SADC_A_CDR0 + 8'h4, res(1), ALL);
        apb(0, `SADC_A_LAST, res(3), ALL);
        apb(0, `SADC_A_FLAGS, 0, ALL);
        chk("irq", irq, 0);
        run(32'h02000110, 1, 2, 0);
        chk("dma_size_16", dma_size_16, 0);
        apb(0, `SADC_A_CDR0 + 8'h4, res(1) >> 2, ALL);
        apb(0, `SADC_A_LAST, res(3) >> 2, ALL);
        for (int c = 1; c < 8; c++)
            run(32'h02000101 | ((c - 1) << 1), 1, 2, c);
        run(32'h02000101, 1, 2, 0);
        run(32'h00003F00, 63, 0, 0);
        run(32'h02000120, 1, 2, 8);
        n = dmas;
        r = rises;
        cv = convs;
        repeat (300) @(posedge pclk);
        chk("dma_count", dmas, n);
        chk("conv_count", convs, cv);
        chk("dma_total", dmas, 3);
        chk("adc_clk_rises", rises, r);
        chk("ana_power_on", ana_power_on, 0);
        end_of_test();
    end
endmodule // sadc_top_tb

// File: verilog/sadc_consts.svh
// Register offsets, field positions and timing counts of the converter
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH
`define SADC_A_CMD    8'h00
`define SADC_A_CFG    8'h04
`define SADC_A_CHEN   8'h10
`define SADC_A_CHDIS  8'h14
`define SADC_A_CHST   8'h18
`define SADC_A_FLAGS  8'h1C
`define SADC_A_LAST   8'h20
`define SADC_A_IEN    8'h24
`define SADC_A_IDIS   8'h28
`define SADC_A_IMASK  8'h2C
`define SADC_A_CDR0   8'h30
`define SADC_A_CDR7   8'h4C
`define SADC_B_SWRST  0
`define SADC_B_START  1
`define SADC_F_HW_TRIGGER_ENABLE  0
`define SADC_F_HW_TRIGGER_SELECT 3:1
`define SADC_F_LOW_RESOLUTION_SELECT 4
`define SADC_F_SLEEP  5
`define SADC_F_DIV    13:8
`define SADC_F_STUP   22:16
`define SADC_F_SHT    27:24
`define SADC_CFG_MASK 32'h0F7F3F3F
`define SADC_CFG_RST  32'h00000000
`define SADC_FL_BITS  18
`define SADC_CONV_CYC 10
`define SADC_STUP_MUL 8
`endif

// File: verilog/sadc_pkg.sv
// Types shared by the converter control logic
package sadc_pkg;
    typedef logic [9:0] sadc_data_t;
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_START  = 4'b0010,
        ST_SAMPLE = 4'b0100,
        ST_CONV   = 4'b1000
    } sadc_state_t;
endpackage

// File: verilog/sadc_top.sv
// Control logic of an 8-channel successive-approximation converter
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "sadc_consts.svh"

module sadc_top
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [5:0]        int_trig,
    input  wire logic              ext_trig,
    input  wire sadc_pkg::sadc_data_t ana_result,
    output logic                   ana_power_on,
    output logic                   ana_sample,
    output logic                   ana_convert,
    output logic      [2:0]        ana_channel,
    output logic                   adc_clk,
    output logic                   dma_req,
    output logic                   dma_size_16,
    output logic                   irq
);
    import sadc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [31:0]  cfg_r;
    logic [7:0]   ch_en_r;
    logic [17:0]  imr_r;
    logic [7:0]   eoc_r;
    logic [7:0]   ovr_r;
    logic         result_available_flag_r;
    logic         global_overrun_flag_r;
    sadc_data_t   cdr_r [8];
    sadc_data_t   last_result_register_r;
    logic [2:0]   last_ch_r;
    logic [31:0]  prdata_r;
    logic         dma_req_r;
    logic         irq_r;
    logic [5:0]   div_cnt_r;
    logic         adc_clk_r;
    logic [7:0]   trg_s1_r;
    logic [7:0]   trg_s2_r;
    logic         trg_prev_r;
    sadc_state_t  st_r;
    logic [2:0]   ch_r;
    logic [9:0]   cyc_r;
    logic         ready_r;
    logic         pend_r;
    logic         wr_acc;
    logic         rd_acc;
    logic         cdr_hit;
    logic [7:0]   cdr_off;
    logic [2:0]   cdr_idx;
    logic         mapped;
    logic         swrst;
    logic         sw_start;
    logic         flags_rd;
    logic         last_rd;
    logic [7:0]   cdr_rd_oh;
    logic [31:0]  flags;
    logic         sleep;
    logic         low_resolution_select;
    logic [5:0]   div;
    logic         idle;
    logic         clk_run;
    logic         tick;
    logic         trg_now;
    logic         hw_edge;
    logic         start_req;
    logic [3:0]   first;
    logic [3:0]   nxt;
    logic [9:0]   stup_last;
    logic         done;
    sadc_data_t   res_val;
    logic [7:0]   eoc_set;
    logic [7:0]   eoc_clr;

    // First enabled channel at or above a start index
    function automatic logic [3:0] next_ch(input logic [7:0] m,
                                           input logic [3:0] from);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--)
            if (m[i] && 4'(i) >= from)
                r = {1'b1, 3'(i)};
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign wr_acc    = psel & penable & pwrite;
    assign rd_acc    = psel & penable & ~pwrite;
    assign cdr_off   = paddr - `SADC_A_CDR0;
    assign cdr_idx   = cdr_off[4:2];
    assign cdr_hit   = paddr >= `SADC_A_CDR0 && paddr <= `SADC_A_CDR7
                       && paddr[1:0] == 2'h0;
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~mapped;
    assign prdata    = prdata_r;
    assign swrst     = wr_acc && paddr == `SADC_A_CMD
                       && pwdata[`SADC_B_SWRST];
    assign sw_start  = wr_acc && paddr == `SADC_A_CMD
                       && pwdata[`SADC_B_START];
    assign flags_rd  = rd_acc && paddr == `SADC_A_FLAGS;
    assign last_rd   = rd_acc && paddr == `SADC_A_LAST;
    assign cdr_rd_oh = (rd_acc && cdr_hit) ? 8'h01 << cdr_idx : 8'h00;
    assign flags     = {14'h0, global_overrun_flag_r, result_available_flag_r, ovr_r, eoc_r};

    always_comb
    begin
        case (paddr)
            `SADC_A_CMD, `SADC_A_CFG, `SADC_A_CHEN, `SADC_A_CHDIS,
            `SADC_A_CHST, `SADC_A_FLAGS, `SADC_A_LAST, `SADC_A_IEN,
            `SADC_A_IDIS, `SADC_A_IMASK: mapped = 1'b1;
            default: mapped = cdr_hit;
        endcase
    end

    // Read data is captured in the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h0;
        else if (psel && !penable)
        begin
            case (paddr)
                `SADC_A_CFG:   prdata_r <= cfg_r;
                `SADC_A_CHST:  prdata_r <= {24'h0, ch_en_r};
                `SADC_A_FLAGS: prdata_r <= flags;
                `SADC_A_LAST:  prdata_r <= {22'h0, last_result_register_r};
                `SADC_A_IMASK: prdata_r <= {14'h0, imr_r};
                default:       prdata_r <= cdr_hit ?
                                   {22'h0, cdr_r[cdr_idx]} : 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration, channel enables and interrupt mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_r   <= `SADC_CFG_RST;
            ch_en_r <= 8'h00;
            imr_r   <= 18'h0;
        end
        else if (swrst)
        begin
            cfg_r   <= `SADC_CFG_RST;
            ch_en_r <= 8'h00;
            imr_r   <= 18'h0;
        end
        else if (wr_acc)
        begin
            case (paddr)
                `SADC_A_CFG:   cfg_r   <= pwdata & `SADC_CFG_MASK;
                `SADC_A_CHEN:  ch_en_r <= ch_en_r | pwdata[7:0];
                `SADC_A_CHDIS: ch_en_r <= ch_en_r & ~pwdata[7:0];
                `SADC_A_IEN:   imr_r   <= imr_r | pwdata[17:0];
                `SADC_A_IDIS:  imr_r   <= imr_r & ~pwdata[17:0];
                default:       cfg_r   <= cfg_r;
            endcase
        end
    end

    assign sleep                 = cfg_r[`SADC_F_SLEEP];
    assign low_resolution_select = cfg_r[`SADC_F_LOW_RESOLUTION_SELECT];
    assign div                   = cfg_r[`SADC_F_DIV];
    assign dma_size_16           = ~low_resolution_select;

    ////////////////////////////////////////////////////////////////////////
    // Converter clock divider
    assign idle         = st_r == ST_IDLE;
    assign ana_power_on = ~sleep | ~idle;
    assign clk_run      = ana_power_on;
    assign tick         = clk_run && div_cnt_r >= div && !adc_clk_r;
    assign adc_clk      = adc_clk_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_r <= 6'h0;
            adc_clk_r <= 1'b0;
        end
        else if (!clk_run || swrst)
        begin
            div_cnt_r <= 6'h0;
            adc_clk_r <= 1'b0;
        end
        else if (div_cnt_r >= div)
        begin
            div_cnt_r <= 6'h0;
            adc_clk_r <= ~adc_clk_r;
        end
        else
            div_cnt_r <= div_cnt_r + 6'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger synchronisers and edge detect
    assign trg_now   = trg_s2_r[cfg_r[`SADC_F_HW_TRIGGER_SELECT]];
    assign hw_edge   = cfg_r[`SADC_F_HW_TRIGGER_ENABLE] & trg_now & ~trg_prev_r;
    assign start_req = sw_start | hw_edge;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trg_s1_r   <= 8'h00;
            trg_s2_r   <= 8'h00;
            trg_prev_r <= 1'b0;
        end
        else
        begin
            trg_s1_r   <= {1'b0, ext_trig, int_trig};
            trg_s2_r   <= trg_s1_r;
            trg_prev_r <= trg_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    assign first     = next_ch(ch_en_r, 4'h0);
    assign nxt       = next_ch(ch_en_r, {1'b0, ch_r} + 4'h1);
    assign stup_last = 10'(({3'h0, cfg_r[`SADC_F_STUP]} + 10'h1)
                       * `SADC_STUP_MUL - 1);
    assign done      = st_r == ST_CONV && tick
                       && cyc_r == 10'(`SADC_CONV_CYC - 1);
    assign res_val   = low_resolution_select ?
                       {2'h0, ana_result[9:2]} : ana_result;
    assign ana_sample  = st_r == ST_SAMPLE;
    assign ana_convert = st_r == ST_CONV;
    assign ana_channel = ch_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r    <= ST_IDLE;
            ch_r    <= 3'h0;
            cyc_r   <= 10'h0;
            ready_r <= 1'b0;
            pend_r  <= 1'b0;
        end
        else if (swrst)
        begin
            st_r    <= ST_IDLE;
            ch_r    <= 3'h0;
            cyc_r   <= 10'h0;
            ready_r <= 1'b0;
            pend_r  <= 1'b0;
        end
        else
        begin
            if (!ana_power_on)
                ready_r <= 1'b0;
            if (start_req && !idle && !sleep)
                pend_r <= 1'b1;
            case (st_r)
                ST_IDLE:
                begin
                    cyc_r <= 10'h0;
                    if ((start_req || pend_r) && first[3])
                    begin
                        ch_r <= first[2:0];
                        // Warm cell waits for a tick: sampling spans whole clocks
                        if (!ready_r || tick)
                        begin
                            pend_r <= 1'b0;
                            st_r   <= ready_r ? ST_SAMPLE : ST_START;
                        end
                        else
                            pend_r <= 1'b1;
                    end
                    else
                        pend_r <= 1'b0;
                end
                ST_START:
                    if (tick)
                    begin
                        if (cyc_r == stup_last)
                        begin
                            cyc_r   <= 10'h0;
                            ready_r <= 1'b1;
                            st_r    <= ST_SAMPLE;
                        end
                        else
                            cyc_r <= cyc_r + 10'h1;
                    end
                ST_SAMPLE:
                    if (tick)
                    begin
                        if (cyc_r == {6'h0, cfg_r[`SADC_F_SHT]})
                        begin
                            cyc_r <= 10'h0;
                            st_r  <= ST_CONV;
                        end
                        else
                            cyc_r <= cyc_r + 10'h1;
                    end
                ST_CONV:
                    if (tick)
                    begin
                        if (done)
                        begin
                            cyc_r <= 10'h0;
                            ch_r  <= nxt[2:0];
                            st_r  <= nxt[3] ? ST_SAMPLE : ST_IDLE;
                        end
                        else
                            cyc_r <= cyc_r + 10'h1;
                    end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Results
    genvar g;
    for (g = 0; g < 8; g++)
    begin : g_cdr
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                cdr_r[g] <= 10'h0;
            else if (swrst)
                cdr_r[g] <= 10'h0;
            else if (done && ch_r == 3'(g))
                cdr_r[g] <= res_val;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_result_register_r    <= 10'h0;
            last_ch_r <= 3'h0;
        end
        else if (swrst)
        begin
            last_result_register_r    <= 10'h0;
            last_ch_r <= 3'h0;
        end
        else if (done)
        begin
            last_result_register_r    <= res_val;
            last_ch_r <= ch_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags, DMA request and interrupt
    assign eoc_set = done ? 8'h01 << ch_r : 8'h00;
    assign eoc_clr = cdr_rd_oh
                     | (last_rd ? 8'h01 << last_ch_r : 8'h00);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            eoc_r   <= 8'h00;
            ovr_r   <= 8'h00;
            result_available_flag_r  <= 1'b0;
            global_overrun_flag_r <= 1'b0;
        end
        else if (swrst)
        begin
            eoc_r   <= 8'h00;
            ovr_r   <= 8'h00;
            result_available_flag_r  <= 1'b0;
            global_overrun_flag_r <= 1'b0;
        end
        else
        begin
            eoc_r   <= (eoc_r & ~eoc_clr) | eoc_set;
            ovr_r   <= (ovr_r & ~{8{flags_rd}})
                       | (eoc_set & eoc_r);
            result_available_flag_r  <= (result_available_flag_r & ~last_rd) | done;
            global_overrun_flag_r <= (global_overrun_flag_r & ~flags_rd) | (done & result_available_flag_r);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dma_req_r <= 1'b0;
            irq_r     <= 1'b0;
        end
        else
        begin
            dma_req_r <= done & ~result_available_flag_r & ch_en_r[ch_r];
            irq_r     <= |(flags[`SADC_FL_BITS-1:0] & imr_r);
        end
    end

    assign dma_req = dma_req_r;
    assign irq     = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic        [10:0] tk_r;
    logic        [6:0]  hi_r;
    sadc_state_t        st_d_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tk_r   <= 11'h0;
            hi_r   <= 7'h0;
            st_d_r <= ST_IDLE;
        end
        else
        begin
            st_d_r <= st_r;
            tk_r   <= (st_r != st_d_r) ? {10'h0, tick} : tk_r + 11'(tick);
            hi_r   <= adc_clk_r ? hi_r + 7'h1 : 7'h0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_clk_half: assert property (
        $fell(adc_clk_r) && clk_run && $past(clk_run) && $stable(div)
        |-> $past(hi_r) == {1'b0, div})
        else $error("converter clock half period wrong");
    a_conv_len: assert property (
        st_r == ST_CONV ##1 st_r != ST_CONV
        |-> $past(tk_r) == 11'(`SADC_CONV_CYC - 1))
        else $error("conversion tick count wrong");
    a_sample_len: assert property (
        st_r == ST_SAMPLE ##1 st_r == ST_CONV
        |-> $past(tk_r) == {7'h0, cfg_r[`SADC_F_SHT]})
        else $error("sample-hold tick count wrong");
    a_startup_len: assert property (
        st_r == ST_START ##1 st_r == ST_SAMPLE
        |-> $past(tk_r) == {1'b0, stup_last})
        else $error("start-up tick count wrong");
    a_result_store: assert property (
        done |=> last_result_register_r == $past(res_val) && cdr_r[last_ch_r] == last_result_register_r)
        else $error("result not stored");
    a_low_resolution_select_top: assert property (
        done && low_resolution_select |=> last_result_register_r[9:8] == 2'h0)
        else $error("low resolution upper bits set");
    a_flags_set: assert property (
        done |=> eoc_r[last_ch_r] && result_available_flag_r)
        else $error("done flags not set");
    a_global_ovr: assert property (
        done && result_available_flag_r |=> global_overrun_flag_r ##1 (global_overrun_flag_r || $past(flags_rd)))
        else $error("global overrun missed");
    a_ovr_clear: assert property (
        flags_rd && !done |=> ovr_r == 8'h00 && !global_overrun_flag_r)
        else $error("overrun flags not cleared");
    a_sleep_stop: assert property (
        sleep && idle |-> !ana_power_on ##1 !adc_clk_r)
        else $error("sleep clock not stopped");
    a_dma_pulse: assert property (
        dma_req |-> $past(done) && result_available_flag_r ##1 !dma_req)
        else $error("bad DMA request");

endmodule // sadc_top
